/* File: core/qrgc_pkg.sv */
package qrgc_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS         = 40;
    localparam int CLK_HZ         = 25000000;
    localparam int CNT_W          = 12;
    localparam int ENTRY_W        = 20;
    localparam int BT_W           = 9;
    localparam int RING_LONG_NS   = 10000;
    localparam int RING_SHORT_NS  = 2500;
    localparam int MAX_OFF_NS     = 50000;
    localparam int MAX_ON_NS      = 22000;
    localparam int LEB_NS         = 220;
    localparam int SW_MASK_NS     = 200;
    localparam int BURST_ENTRY_NS = 20000000;
    localparam int BURST_FREQ_HZ  = 52000;

    // least times round up, longest times round down
    localparam logic [CNT_W-1:0] RING_LONG_CYC  = CNT_W'((RING_LONG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RING_SHORT_CYC = CNT_W'((RING_SHORT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] MAX_OFF_CYC    = CNT_W'(MAX_OFF_NS / CLK_NS);
    localparam logic [CNT_W-1:0] MAX_ON_CYC     = CNT_W'(MAX_ON_NS / CLK_NS);
    localparam logic [CNT_W-1:0] LEB_CYC        = CNT_W'((LEB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] SW_MASK_CYC    = CNT_W'((SW_MASK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [BT_W-1:0]  BURST_PER_CYC  = BT_W'(CLK_HZ / BURST_FREQ_HZ);
    localparam logic [CNT_W-1:0] BURST_DUTY_CYC = CNT_W'(CLK_HZ / BURST_FREQ_HZ / 2);
    localparam int               ENTRY_DEF_CYC  = BURST_ENTRY_NS / CLK_NS;

    // ----------------------------------------
    // counters and limits
    // ----------------------------------------
    localparam logic [2:0] VALLEY_MAX  = 3'h7;
    localparam logic [2:0] SKIP_MIN    = 3'h1;
    localparam logic [2:0] SKIP_MAX    = 3'h7;
    localparam int         FOLD_W      = 4;
    localparam int         LIM_W       = 8;
    localparam logic [7:0] LIMIT_FULL  = 8'hC8;
    localparam logic [7:0] LIMIT_BURST = 8'h44;

    // ----------------------------------------
    // comparator bundle positions
    // ----------------------------------------
    localparam int CMP_RING  = 0;
    localparam int CMP_VAL   = 1;
    localparam int CMP_FDBK  = 2;
    localparam int CMP_CL    = 3;
    localparam int CMP_SW    = 4;
    localparam int CMP_ENTRY = 5;
    localparam int CMP_UPPER = 6;
    localparam int CMP_LOWER = 7;
    localparam int CMP_EXIT  = 8;
    localparam int CMP_PEAK  = 9;
    localparam int NCMP      = 10;

    typedef enum logic [1:0] {
        ST_SUPPRESS,
        ST_WAIT,
        ST_ON,
        ST_LATCHED
    } qrgc_state_t;

endpackage : qrgc_pkg

/* File: core/qrgc_sync.sv */
`timescale 1ns/1ps
module qrgc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ----------------------------------------
    // two-stage synchroniser per comparator
    // ----------------------------------------
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (srst) begin
                meta_q[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else if (ce) begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end

endmodule : qrgc_sync

/* File: core/qrgc_gate_ctrl.sv */
`timescale 1ns/1ps
module qrgc_gate_ctrl #(
    parameter logic [qrgc_pkg::ENTRY_W-1:0] ENTRY_CYC = qrgc_pkg::ENTRY_W'(qrgc_pkg::ENTRY_DEF_CYC)
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        ce,
    input  wire logic                        ringLowCmp,
    input  wire logic                        valleyCmp,
    input  wire logic                        fdbkTripCmp,
    input  wire logic                        curLimCmp,
    input  wire logic                        shortCmp,
    input  wire logic                        fdbkEntryCmp,
    input  wire logic                        fdbkUpperCmp,
    input  wire logic                        fdbkLowerCmp,
    input  wire logic                        fdbkExitCmp,
    input  wire logic                        burstPeakCmp,
    input  wire logic                        skipUp,
    input  wire logic                        skipDown,
    input  wire logic                        skipLoad,
    input  wire logic [qrgc_pkg::FOLD_W-1:0] foldExcess,
    output logic                             gate,
    output logic      [qrgc_pkg::LIM_W-1:0]  senseLimit,
    output logic                             burstMode,
    output logic                             latchedOff
);
    import qrgc_pkg::*;

    // ----------------------------------------
    // comparator synchronisation
    // ----------------------------------------
    logic [NCMP-1:0] cmpRaw;
    logic [NCMP-1:0] cmp;

    assign cmpRaw = {burstPeakCmp, fdbkExitCmp, fdbkLowerCmp, fdbkUpperCmp, fdbkEntryCmp,
                     shortCmp, curLimCmp, fdbkTripCmp, valleyCmp, ringLowCmp};

    qrgc_sync #(.W(NCMP)) u_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .d    (cmpRaw),
        .q    (cmp)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    qrgc_state_t         state_q;
    logic                gate_q;
    logic                latchedOff_q;
    logic [CNT_W-1:0]    onCnt_q;
    logic [CNT_W-1:0]    offCnt_q;
    logic [CNT_W-1:0]    swCnt_q;
    logic [2:0]          valleyCnt_q;
    logic [2:0]          skipCnt_q;
    logic                valleyPrev_q;
    logic [ENTRY_W-1:0]  entryCnt_q;
    logic                burstMode_q;
    logic                burstRun_q;
    logic [BT_W-1:0]     burstTmr_q;
    logic [LIM_W-1:0]    limit_q;

    logic                blanked;
    logic [CNT_W-1:0]    ringLen;
    logic                valleyEdge;
    logic                swTrip;
    logic                goOn;
    logic                goOff;
    logic                burstTick;
    logic                burstExit;

    // nonlinear offset, kept small so the limit never wraps
    function automatic logic [LIM_W-1:0] foldOffset(input logic [FOLD_W-1:0] ex);
        logic [LIM_W-1:0] r;
        r = 8'h00;
        case (ex)
            4'h0:    r = 8'h00;
            4'h1:    r = 8'h02;
            4'h2:    r = 8'h05;
            4'h3:    r = 8'h09;
            4'h4:    r = 8'h0E;
            4'h5:    r = 8'h13;
            4'h6:    r = 8'h18;
            4'h7:    r = 8'h1D;
            4'h8:    r = 8'h22;
            4'h9:    r = 8'h27;
            4'hA:    r = 8'h2B;
            4'hB:    r = 8'h2F;
            4'hC:    r = 8'h33;
            4'hD:    r = 8'h37;
            4'hE:    r = 8'h3B;
            default: r = 8'h3F;
        endcase
        return r;
    endfunction : foldOffset

    // ----------------------------------------
    // decisions
    // ----------------------------------------
    always_comb begin
        blanked    = onCnt_q < LEB_CYC;
        ringLen    = cmp[CMP_RING] ? RING_LONG_CYC : RING_SHORT_CYC;
        valleyEdge = cmp[CMP_VAL] & ~valleyPrev_q;
        burstTick  = burstTmr_q == '0;
        burstExit  = burstMode_q & cmp[CMP_EXIT];
        // spike mask first, and never inside the leading-edge window
        swTrip     = (swCnt_q >= SW_MASK_CYC) & ~blanked;
        if (burstMode_q) begin
            goOn = burstRun_q & burstTick;
        end else begin
            goOn = (valleyCnt_q >= skipCnt_q) || (offCnt_q >= MAX_OFF_CYC);
        end
        goOff = onCnt_q >= MAX_ON_CYC;
        if (!blanked) begin
            if (burstMode_q) begin
                goOff = goOff | cmp[CMP_PEAK] | cmp[CMP_CL];
            end else begin
                goOff = goOff | cmp[CMP_FDBK] | cmp[CMP_CL];
            end
        end
        if (burstMode_q && onCnt_q >= BURST_DUTY_CYC - 1'b1) begin
            goOff = 1'b1;
        end
    end

    // ----------------------------------------
    // gate state machine
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q      <= ST_SUPPRESS;
            gate_q       <= 1'b0;
            latchedOff_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ST_SUPPRESS: begin
                    if (offCnt_q >= ringLen) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (goOn) begin
                        state_q <= ST_ON;
                        gate_q  <= 1'b1;
                    end
                end
                ST_ON: begin
                    if (swTrip) begin
                        state_q      <= ST_LATCHED;
                        gate_q       <= 1'b0;
                        latchedOff_q <= 1'b1;
                    end else if (goOff) begin
                        state_q <= ST_SUPPRESS;
                        gate_q  <= 1'b0;
                    end
                end
                ST_LATCHED: begin
                    gate_q <= 1'b0;
                end
                default: begin
                    state_q <= ST_SUPPRESS;
                    gate_q  <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // on, off and spike counters
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            onCnt_q  <= '0;
            offCnt_q <= '0;
            swCnt_q  <= '0;
        end else if (ce) begin
            onCnt_q  <= gate_q ? (onCnt_q + {{(CNT_W-1){1'b0}}, ~&onCnt_q}) : '0;
            offCnt_q <= !gate_q ? (offCnt_q + {{(CNT_W-1){1'b0}}, ~&offCnt_q}) : '0;
            // any gap in the comparator restarts the mask
            swCnt_q  <= (gate_q && cmp[CMP_SW]) ?
                        (swCnt_q + {{(CNT_W-1){1'b0}}, ~&swCnt_q}) : '0;
        end
    end

    // ----------------------------------------
    // valley and skip counters
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            valleyCnt_q  <= '0;
            valleyPrev_q <= 1'b0;
        end else if (ce) begin
            valleyPrev_q <= cmp[CMP_VAL];
            if (gate_q) begin
                valleyCnt_q <= '0;
            end else if (valleyEdge && valleyCnt_q < VALLEY_MAX) begin
                valleyCnt_q <= valleyCnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            skipCnt_q <= SKIP_MIN;
        end else if (ce) begin
            if (burstExit || skipLoad) begin
                skipCnt_q <= SKIP_MIN;
            end else if (skipUp && skipCnt_q < SKIP_MAX) begin
                skipCnt_q <= skipCnt_q + 3'h1;
            end else if (skipDown && skipCnt_q > SKIP_MIN) begin
                skipCnt_q <= skipCnt_q - 3'h1;
            end
        end
    end

    // ----------------------------------------
    // burst mode
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            entryCnt_q <= '0;
        end else if (ce) begin
            if (!burstMode_q && cmp[CMP_ENTRY] && skipCnt_q == SKIP_MAX) begin
                entryCnt_q <= entryCnt_q + {{(ENTRY_W-1){1'b0}}, ~&entryCnt_q};
            end else begin
                entryCnt_q <= '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            burstMode_q <= 1'b0;
            burstRun_q  <= 1'b0;
        end else if (ce) begin
            if (!burstMode_q) begin
                burstRun_q <= 1'b0;
                if (entryCnt_q >= ENTRY_CYC) begin
                    burstMode_q <= 1'b1;
                end
            end else if (burstExit) begin
                burstMode_q <= 1'b0;
                burstRun_q  <= 1'b0;
            end else if (cmp[CMP_UPPER]) begin
                burstRun_q <= 1'b1;
            end else if (cmp[CMP_LOWER]) begin
                burstRun_q <= 1'b0;
            end
        end
    end

    // free-running only while burstRun_q is set, so the first pulse starts at once
    always_ff @(posedge clk) begin
        if (srst) begin
            burstTmr_q <= '0;
        end else if (ce) begin
            if (!burstRun_q || burstTmr_q == BURST_PER_CYC - 1'b1) begin
                burstTmr_q <= '0;
            end else begin
                burstTmr_q <= burstTmr_q + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // sense limit
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            limit_q <= LIMIT_FULL;
        end else if (ce) begin
            if (burstMode_q) begin
                limit_q <= LIMIT_BURST;
            end else begin
                limit_q <= LIMIT_FULL - foldOffset(foldExcess);
            end
        end
    end

    assign gate       = gate_q;
    assign senseLimit = limit_q;
    assign burstMode  = burstMode_q;
    assign latchedOff = latchedOff_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_rise;
        !gate_q ##1 gate_q;
    endsequence

    sequence s_fall;
        gate_q ##1 !gate_q;
    endsequence

    property p_ring_long;
        (ce && state_q == ST_SUPPRESS && cmp[CMP_RING] && offCnt_q < RING_LONG_CYC)
            |=> state_q != ST_WAIT;
    endproperty
    a_ring_long: assert property (p_ring_long) else $error("long suppression cut short");

    property p_ring_short;
        (ce && state_q == ST_SUPPRESS && !cmp[CMP_RING] && offCnt_q >= RING_SHORT_CYC)
            |=> state_q == ST_WAIT;
    endproperty
    a_ring_short: assert property (p_ring_short) else $error("short suppression not ended");

    property p_ring_hold;
        s_fall |-> !gate_q [*8];
    endproperty
    a_ring_hold: assert property (p_ring_hold) else $error("gate rose in suppression");

    property p_valley_on;
        (ce && state_q == ST_WAIT && !burstMode_q && valleyCnt_q >= skipCnt_q) |=> gate_q;
    endproperty
    a_valley_on: assert property (p_valley_on) else $error("valley turn-on missed");

    property p_max_off;
        (ce && state_q == ST_WAIT && !burstMode_q && offCnt_q >= MAX_OFF_CYC) |=> gate_q;
    endproperty
    a_max_off: assert property (p_max_off) else $error("max off-time not enforced");

    property p_fdbk_off;
        (ce && state_q == ST_ON && !burstMode_q && !blanked && cmp[CMP_FDBK]) |=> !gate_q;
    endproperty
    a_fdbk_off: assert property (p_fdbk_off) else $error("feedback trip ignored");

    property p_leb;
        s_rise |-> gate_q [*6];
    endproperty
    a_leb: assert property (p_leb) else $error("pulse shorter than mask");

    property p_max_on;
        (ce && gate_q && onCnt_q >= MAX_ON_CYC) |=> !gate_q;
    endproperty
    a_max_on: assert property (p_max_on) else $error("max on-time exceeded");

    property p_cur_lim;
        (ce && state_q == ST_ON && !blanked && cmp[CMP_CL]) |=> !gate_q;
    endproperty
    a_cur_lim: assert property (p_cur_lim) else $error("current limit ignored");

    property p_sw_mask;
        $rose(latchedOff_q) |-> $past(swCnt_q) >= SW_MASK_CYC;
    endproperty
    a_sw_mask: assert property (p_sw_mask) else $error("short latch before mask");

    property p_latch;
        latchedOff_q |=> latchedOff_q && !gate_q;
    endproperty
    a_latch: assert property (p_latch) else $error("latch-off released");

    property p_entry;
        $rose(burstMode_q) |-> $past(entryCnt_q) >= ENTRY_CYC && $past(skipCnt_q) == SKIP_MAX;
    endproperty
    a_entry: assert property (p_entry) else $error("burst entered early");

    property p_burst_start;
        (ce && burstMode_q && state_q != ST_ON && !(burstRun_q && burstTick)) |=> !gate_q;
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("burst pulse off timer");

    property p_duty;
        (ce && gate_q && burstMode_q && onCnt_q >= BURST_DUTY_CYC - 1'b1) |=> !gate_q;
    endproperty
    a_duty: assert property (p_duty) else $error("burst duty above half");

    property p_burst_stop;
        (ce && burstMode_q && cmp[CMP_LOWER] && !cmp[CMP_UPPER]) |=> !burstRun_q;
    endproperty
    a_burst_stop: assert property (p_burst_stop) else $error("burst not stopped");

    property p_exit;
        (ce && burstExit) |=> !burstMode_q && skipCnt_q == SKIP_MIN ##1 limit_q != LIMIT_BURST;
    endproperty
    a_exit: assert property (p_exit) else $error("burst exit wrong");

    property p_valley_cnt;
        (ce && !gate_q && valleyEdge && valleyCnt_q < VALLEY_MAX)
            |=> valleyCnt_q == $past(valleyCnt_q) + 3'h1;
    endproperty
    a_valley_cnt: assert property (p_valley_cnt) else $error("valley count slip");

    property p_skip_range;
        skipCnt_q >= SKIP_MIN && skipCnt_q <= SKIP_MAX;
    endproperty
    a_skip_range: assert property (p_skip_range) else $error("skip counter out of range");

    property p_reset;
        @(posedge clk) disable iff (1'b0) srst |=> !gate_q && skipCnt_q == SKIP_MIN && !burstMode_q;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : qrgc_gate_ctrl

/* File: test/qrgc_switch_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// power switch and transformer stand-in
// ----------------------------------------
// sense ramps only while the switch conducts; ringing dips come only after turn-off,
// so a valley can never be seen during on-time
module qrgc_switch_model (
    input  wire logic        clk,
    input  wire logic        gate,
    input  wire logic [11:0] tripAt,
    input  wire logic [11:0] valleyPer,
    output logic             senseHi,
    output logic             valleyCmp
);
    logic [11:0] onCnt;
    logic [11:0] offCnt;

    initial begin
        onCnt     = 12'h000;
        offCnt    = 12'h000;
        senseHi   = 1'b0;
        valleyCmp = 1'b0;
    end

    // tripAt of zero means the sense never reaches the feedback level
    always @(negedge clk) begin
        onCnt     <= gate ? onCnt + 12'h001 : 12'h000;
        offCnt    <= gate ? 12'h000 : offCnt + 12'h001;
        senseHi   <= gate && tripAt != 12'h000 && onCnt >= tripAt;
        valleyCmp <= !gate && valleyPer != 12'h000
                     && (offCnt % valleyPer) == valleyPer - 12'h001;
    end
endmodule : qrgc_switch_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import qrgc_pkg::*;
    typedef struct packed {
        logic [11:0] offLo;
        logic [11:0] offHi;
        logic [11:0] onLo;
        logic [11:0] onHi;
    } qrgc_note_t;

    logic        clk = 1'b0;
    logic        srst, ce, ringLowCmp, valleyCmp, curLimCmp, shortCmp, senseHi;
    logic        fdbkEntryCmp, fdbkUpperCmp, fdbkLowerCmp, fdbkExitCmp;
    logic        skipUp, skipDown, skipLoad;
    logic        gate, burstMode, latchedOff;
    logic [3:0]  foldExcess;
    logic [7:0]  senseLimit;
    logic [11:0] tripAt, valleyPer;
    int          miscompares, totalChecks, falls, onLen, offLen, n;
    integer      seed;
    qrgc_note_t  notes[$];
    qrgc_note_t  nt;

    always #20 clk = ~clk;

    qrgc_gate_ctrl #(.ENTRY_CYC(ENTRY_W'(50))) dut (
        .clk(clk), .srst(srst), .ce(ce), .ringLowCmp(ringLowCmp), .valleyCmp(valleyCmp),
        .fdbkTripCmp(senseHi), .curLimCmp(curLimCmp), .shortCmp(shortCmp),
        .fdbkEntryCmp(fdbkEntryCmp), .fdbkUpperCmp(fdbkUpperCmp),
        .fdbkLowerCmp(fdbkLowerCmp), .fdbkExitCmp(fdbkExitCmp), .burstPeakCmp(senseHi),
        .skipUp(skipUp), .skipDown(skipDown), .skipLoad(skipLoad), .foldExcess(foldExcess),
        .gate(gate), .senseLimit(senseLimit), .burstMode(burstMode), .latchedOff(latchedOff)
    );

    qrgc_switch_model partner (
        .clk(clk), .gate(gate), .tripAt(tripAt), .valleyPer(valleyPer),
        .senseHi(senseHi), .valleyCmp(valleyCmp)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic ok, input string what);
        totalChecks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task automatic step(ref logic s, input int k);
        repeat (k) begin
            s = 1'b1;
            cyc(1);
            s = 1'b0;
            cyc(1);
        end
    endtask : step

    // note one pulse's off and on length, then wait for its end
    task automatic pulse(input int offLo, input int offHi, input int onLo, input int onHi);
        int f;
        f = falls;
        notes.push_back({12'(offLo), 12'(offHi), 12'(onLo), 12'(onHi)});
        for (int i = 0; i < 3000 && falls == f; i++) cyc(1);
        if (falls == f) check(1'b0, "no pulse");
    endtask : pulse

    // first pulse after a change straddles old and new settings
    task automatic fresh(input int offLo, input int offHi, input int onLo, input int onHi);
        pulse(0, 4095, 0, 4095);
        pulse(offLo, offHi, onLo, onHi);
    endtask : fresh

    task automatic waitHigh;
        for (int i = 0; i < 3000 && gate !== 1'b1; i++) cyc(1);
    endtask : waitHigh

    task automatic printVerdict;
        $display("checks %0d, mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : printVerdict

    // ----------------------------------------
    // pulse monitor
    // ----------------------------------------
    always @(posedge clk) begin
        #1;
        if (gate === 1'b1) onLen++;
        else if (onLen != 0) begin
            falls++;
            if (notes.size() != 0) begin
                nt = notes.pop_front();
                check(offLen >= nt.offLo && offLen <= nt.offHi && onLen >= nt.onLo
                      && onLen <= nt.onHi, "pulse timing");
            end
            onLen = 0;
            offLen = 1;
        end else offLen++;
    end

    // hang guard, well beyond the whole sequence
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        printVerdict();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        seed = 3;
        {srst, ce} = 2'b11;
        {ringLowCmp, curLimCmp, shortCmp, fdbkEntryCmp, fdbkUpperCmp} = 5'h00;
        {fdbkLowerCmp, fdbkExitCmp, skipUp, skipDown, skipLoad} = 5'h00;
        foldExcess = 4'h0;
        tripAt = 12'd20;
        valleyPer = 12'd4;
        cyc(2);
        srst = 1'b0;
        check(gate === 1'b0 && senseLimit === LIMIT_FULL && burstMode === 1'b0, "reset");
        fresh(63, 70, 20, 25);
        ringLowCmp = 1'b1;
        fresh(250, 257, 20, 25);
        ringLowCmp = 1'b0;
        tripAt = 12'(10 + {$random(seed)} % 30);
        fresh(63, 70, tripAt, tripAt + 5);
        tripAt = 12'd2;
        fresh(63, 70, 6, 9);
        tripAt = 12'd0;
        fresh(63, 70, 550, 553);
        curLimCmp = 1'b1;
        fresh(63, 70, 6, 9);
        curLimCmp = 1'b0;
        tripAt = 12'd20;
        valleyPer = 12'd100;
        step(skipUp, 2);
        fresh(299, 308, 20, 25);
        step(skipUp, 10);
        fresh(699, 708, 20, 25);
        step(skipDown, 10);
        fresh(99, 108, 20, 25);
        valleyPer = 12'd0;
        fresh(1250, 1256, 20, 25);
        valleyPer = 12'd100;
        step(skipUp, 3);
        step(skipLoad, 1);
        fresh(99, 108, 20, 25);
        // enable low must freeze a running pulse, counters included
        waitHigh();
        n = falls;
        ce = 1'b0;
        cyc(100);
        check(gate === 1'b1 && falls == n, "enable freeze");
        ce = 1'b1;
        foldExcess = 4'hF;
        cyc(4);
        check(senseLimit < LIMIT_FULL, "foldback limit");
        foldExcess = 4'h0;
        cyc(4);
        check(senseLimit === LIMIT_FULL, "full limit");
        // burst entry needs skip at seven; six must not be enough
        step(skipUp, 5);
        fdbkEntryCmp = 1'b1;
        cyc(100);
        check(burstMode === 1'b0, "early burst");
        step(skipUp, 1);
        cyc(60);
        check(burstMode === 1'b1 && senseLimit === LIMIT_BURST, "burst entry");
        fdbkEntryCmp = 1'b0;
        cyc(50);
        n = falls;
        cyc(600);
        check(falls == n, "burst idle");
        fdbkUpperCmp = 1'b1;
        tripAt = 12'd0;
        cyc(4);
        fdbkUpperCmp = 1'b0;
        fresh(236, 245, 238, 244);
        tripAt = 12'd20;
        fresh(455, 462, 20, 25);
        fdbkLowerCmp = 1'b1;
        cyc(300);
        n = falls;
        cyc(1000);
        check(falls == n, "burst stop");
        fdbkLowerCmp = 1'b0;
        fdbkExitCmp = 1'b1;
        cyc(6);
        check(burstMode === 1'b0 && senseLimit === LIMIT_FULL, "burst exit");
        fdbkExitCmp = 1'b0;
        fresh(99, 108, 20, 25);
        // a short spike must not latch, a held level must
        tripAt = 12'd40;
        waitHigh();
        cyc(10);
        shortCmp = 1'b1;
        cyc(3);
        shortCmp = 1'b0;
        cyc(40);
        check(latchedOff === 1'b0, "spike latched");
        waitHigh();
        cyc(10);
        shortCmp = 1'b1;
        cyc(12);
        check(latchedOff === 1'b1 && gate === 1'b0, "short latch");
        shortCmp = 1'b0;
        n = falls;
        cyc(2000);
        check(gate === 1'b0 && falls == n, "latch holds");
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        check(latchedOff === 1'b0 && gate === 1'b0 && senseLimit === LIMIT_FULL, "rerun");
        printVerdict();
    end
endmodule : tb_top
